// ### logic/gpp_irq_detect.sv
// per-pin edge and level interrupt detection with sticky edge flags
module gpp_irq_detect #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // synchronised pin samples
    input wire logic [W-1:0] pin_now,
    input wire logic [W-1:0] pin_prev,
    // trigger configuration
    input wire logic [W-1:0] sense_level,
    input wire logic [W-1:0] both_edges,
    input wire logic [W-1:0] high_rising,
    input wire logic [W-1:0] enable_mask,
    // write-one clear strobe
    input wire logic [W-1:0] clear,
    // status
    output logic [W-1:0] raw,
    output logic [W-1:0] masked
);
    import gpp_pkg::*;

    typedef struct packed {
        logic [W-1:0] edge_hit;
    } gpp_det_state_t;

    gpp_det_state_t st;
    gpp_det_state_t next_st;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    logic [W-1:0] edge_event;
    logic [W-1:0] level_hit;

    always_comb begin
        rise = pin_now & ~pin_prev;
        fall = ~pin_now & pin_prev;
        edge_event = both_edges & (rise | fall)
            | ~both_edges & (high_rising & rise | ~high_rising & fall);
        level_hit = ~(pin_now ^ high_rising);
        next_st = st;
        // a new edge in the clearing cycle survives the clear
        next_st.edge_hit = (st.edge_hit & ~clear) | (edge_event & ~sense_level);
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // level status follows the pin, so a clear cannot hold it down
    assign raw = (sense_level & level_hit) | (~sense_level & st.edge_hit);
    assign masked = raw & enable_mask;
endmodule

// ### logic/gpp_pkg.sv
// shared constants for the eight-pin port block
package gpp_pkg;
    localparam int NPIN = 8;
    // address bits carrying the data window mask
    localparam int MASK_LSB = 2;
    localparam int MASK_MSB = 9;
    // byte offsets
    localparam logic [11:0] OFS_DATA_END = 12'h03FC;
    localparam logic [11:0] OFS_DIR = 12'h0400;
    localparam logic [11:0] OFS_IS = 12'h0404;
    localparam logic [11:0] OFS_IBE = 12'h0408;
    localparam logic [11:0] OFS_IEV = 12'h040C;
    localparam logic [11:0] OFS_IM = 12'h0410;
    localparam logic [11:0] OFS_RIS = 12'h0414;
    localparam logic [11:0] OFS_MIS = 12'h0418;
    localparam logic [11:0] OFS_ICR = 12'h041C;
    localparam logic [11:0] OFS_AFSEL = 12'h0420;
    localparam logic [11:0] OFS_DR2R = 12'h0500;
    localparam logic [11:0] OFS_DR4R = 12'h0504;
    localparam logic [11:0] OFS_DR8R = 12'h0508;
    localparam logic [11:0] OFS_ODR = 12'h050C;
    localparam logic [11:0] OFS_PUR = 12'h0510;
    localparam logic [11:0] OFS_PDR = 12'h0514;
    localparam logic [11:0] OFS_SLR = 12'h0518;
    localparam logic [11:0] OFS_DEN = 12'h051C;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DR2R = 8'hFF;
    localparam logic [7:0] RST_PUR = 8'hFF;
    localparam logic [7:0] RST_DEN = 8'hFF;
    localparam logic [7:0] RST_AFSEL = 8'h00;
    // default trigger pin index
    localparam int TRIG_PIN_DEFAULT = 4;
    typedef enum logic {GPP_BUS_IDLE, GPP_BUS_ACK} gpp_bus_state_t;
endpackage

// ### logic/gpp_port.sv
// eight-pin general purpose port with masked data window and pin interrupts
//
// Overview of operation
// - pins reset as inputs under software control
// - test-port pins reset under peripheral control
// - any reset restores both pin groups
// - address bits 9..2 mask the data bits
// - data window spans 256 aliased words
// - writes change only mask-selected bits
// - reads return zero for unselected bits
// - reads: outputs give written value, inputs pin
// - direction per pin; software drives outputs only
// - all enabled pin interrupts form one output
// - edge flags stay set until cleared
// - sense, both-edge, event bits pick trigger
// - mask bit one forwards the pin interrupt
// - raw status ignores the mask
// - masked status is raw and mask
// - writing one to clear drops the flag
// - mask pins before changing trigger settings
// - unmasked trigger pin also pulses converter trigger
// - peripheral select hands the pin to peripheral
// - otherwise data register drives and samples pin
// - peripheral mode ignores direction; needs digital enable
module gpp_port
    import gpp_pkg::*;
#(
    parameter logic [7:0] PERIPH_CTRL_RESET = gpp_pkg::RST_AFSEL,
    parameter bit TRIGGER_USED = 1'b0,
    parameter int TRIGGER_PIN = gpp_pkg::TRIG_PIN_DEFAULT
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [11:2] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // pads
    input wire logic [gpp_pkg::NPIN-1:0] PIN_IN,
    output logic [gpp_pkg::NPIN-1:0] PIN_OUT,
    output logic [gpp_pkg::NPIN-1:0] PIN_OE,
    // alternate function peripheral
    input wire logic [gpp_pkg::NPIN-1:0] PERIPH_OUT,
    input wire logic [gpp_pkg::NPIN-1:0] PERIPH_OE,
    output logic [gpp_pkg::NPIN-1:0] PERIPH_IN,
    // pad electrical settings
    output logic [gpp_pkg::NPIN-1:0] PULL_UP_SELECT,
    output logic [gpp_pkg::NPIN-1:0] PULL_DOWN_SELECT,
    output logic [gpp_pkg::NPIN-1:0] DRIVE_LOW_CURRENT_SELECT,
    output logic [gpp_pkg::NPIN-1:0] DRIVE_MID_CURRENT_SELECT,
    output logic [gpp_pkg::NPIN-1:0] DRIVE_HIGH_CURRENT_SELECT,
    output logic [gpp_pkg::NPIN-1:0] SLEW_LIMIT_SELECT,
    output logic [gpp_pkg::NPIN-1:0] DIGITAL_INPUT_ENABLE,
    // interrupt and converter trigger
    output logic PORT_IRQ,
    output logic CONVERTER_TRIGGER
);
    import gpp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        gpp_bus_state_t bus;
        logic [31:0] rdata;
        logic [NPIN-1:0] pin_data_window;
        logic [NPIN-1:0] pin_direction;
        logic [NPIN-1:0] irq_sense_select;
        logic [NPIN-1:0] irq_both_edges;
        logic [NPIN-1:0] irq_polarity_event;
        logic [NPIN-1:0] irq_enable_mask;
        logic [NPIN-1:0] peripheral_control_select;
        logic [NPIN-1:0] drive_low_current_select;
        logic [NPIN-1:0] drive_mid_current_select;
        logic [NPIN-1:0] drive_high_current_select;
        logic [NPIN-1:0] open_drain_select;
        logic [NPIN-1:0] pull_up_select;
        logic [NPIN-1:0] pull_down_select;
        logic [NPIN-1:0] slew_limit_select;
        logic [NPIN-1:0] digital_input_enable;
        logic trig_prev;
        logic trig;
    } gpp_port_state_t;

    gpp_port_state_t st;
    gpp_port_state_t next_st;

    logic [NPIN-1:0] pin_now;
    logic [NPIN-1:0] pin_prev;
    logic [NPIN-1:0] pin_seen;
    logic [NPIN-1:0] seen_prev;
    logic [NPIN-1:0] irq_clear;
    logic [NPIN-1:0] irq_raw_status;
    logic [NPIN-1:0] irq_masked_status;
    logic [NPIN-1:0] sw_mode;
    logic [11:0] byte_addr;
    logic req;
    logic wr_lane0;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // merge a write under a per-bit enable
    function automatic logic [NPIN-1:0] merge(
        input logic [NPIN-1:0] old_val,
        input logic [NPIN-1:0] new_val,
        input logic [NPIN-1:0] en
    );
        merge = (old_val & ~en) | (new_val & en);
    endfunction

    function automatic logic [31:0] widen(input logic [NPIN-1:0] v);
        widen = {{(32 - NPIN){1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input path

    gpp_sync #(
        .W(NPIN)
    ) u_sync (
        .CLK(CLK),
        .SRST(SRST),
        .pin_raw(PIN_IN),
        .pin_now(pin_now),
        .pin_prev(pin_prev)
    );

    // input buffer off means the pin reads low
    assign pin_seen = pin_now & st.digital_input_enable;
    assign seen_prev = pin_prev & st.digital_input_enable;

    gpp_irq_detect #(
        .W(NPIN)
    ) u_detect (
        .CLK(CLK),
        .SRST(SRST),
        .pin_now(pin_seen),
        .pin_prev(seen_prev),
        .sense_level(st.irq_sense_select),
        .both_edges(st.irq_both_edges),
        .high_rising(st.irq_polarity_event),
        .enable_mask(st.irq_enable_mask),
        .clear(irq_clear),
        .raw(irq_raw_status),
        .masked(irq_masked_status)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    assign byte_addr = {ADR_I, 2'b00};
    assign req = CYC_I && STB_I && (st.bus == GPP_BUS_IDLE);
    // data lives in byte lane 0; the other lanes are ignored
    assign wr_lane0 = req && WE_I && SEL_I[0];
    assign irq_clear = (wr_lane0 && byte_addr == OFS_ICR) ? DAT_I[NPIN-1:0] : '0;
    assign sw_mode = ~st.peripheral_control_select;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [NPIN-1:0] mask;
        logic [NPIN-1:0] data_view;
        logic [NPIN-1:0] wd;
        mask = ADR_I[MASK_MSB:MASK_LSB];
        // outputs report the latch, inputs the pin
        data_view = (st.pin_direction & sw_mode & st.pin_data_window)
            | (~(st.pin_direction & sw_mode) & pin_seen);
        wd = DAT_I[NPIN-1:0];
        next_st = st;
        next_st.rdata = st.rdata;

        unique case (st.bus)
            GPP_BUS_IDLE: begin
                if (req) begin
                    next_st.bus = GPP_BUS_ACK;
                end
            end
            GPP_BUS_ACK: begin
                next_st.bus = GPP_BUS_IDLE;
            end
        endcase

        if (req && !WE_I) begin
            if (byte_addr <= OFS_DATA_END) begin
                next_st.rdata = widen(data_view & mask);
            end else begin
                unique case (byte_addr)
                    OFS_DIR: next_st.rdata = widen(st.pin_direction);
                    OFS_IS: next_st.rdata = widen(st.irq_sense_select);
                    OFS_IBE: next_st.rdata = widen(st.irq_both_edges);
                    OFS_IEV: next_st.rdata = widen(st.irq_polarity_event);
                    OFS_IM: next_st.rdata = widen(st.irq_enable_mask);
                    OFS_RIS: next_st.rdata = widen(irq_raw_status);
                    OFS_MIS: next_st.rdata = widen(irq_masked_status);
                    OFS_AFSEL: next_st.rdata = widen(st.peripheral_control_select);
                    OFS_DR2R: next_st.rdata = widen(st.drive_low_current_select);
                    OFS_DR4R: next_st.rdata = widen(st.drive_mid_current_select);
                    OFS_DR8R: next_st.rdata = widen(st.drive_high_current_select);
                    OFS_ODR: next_st.rdata = widen(st.open_drain_select);
                    OFS_PUR: next_st.rdata = widen(st.pull_up_select);
                    OFS_PDR: next_st.rdata = widen(st.pull_down_select);
                    OFS_SLR: next_st.rdata = widen(st.slew_limit_select);
                    OFS_DEN: next_st.rdata = widen(st.digital_input_enable);
                    default: next_st.rdata = '0;
                endcase
            end
        end

        if (wr_lane0) begin
            if (byte_addr <= OFS_DATA_END) begin
                // all 256 aliases hit the same latch
                next_st.pin_data_window = merge(st.pin_data_window, wd, mask);
            end else begin
                unique case (byte_addr)
                    OFS_DIR: next_st.pin_direction = wd;
                    // no spurious-edge guard: software masks first
                    OFS_IS: next_st.irq_sense_select = wd;
                    OFS_IBE: next_st.irq_both_edges = wd;
                    OFS_IEV: next_st.irq_polarity_event = wd;
                    OFS_IM: next_st.irq_enable_mask = wd;
                    OFS_AFSEL: next_st.peripheral_control_select = wd;
                    OFS_DR2R: next_st.drive_low_current_select = wd;
                    OFS_DR4R: next_st.drive_mid_current_select = wd;
                    OFS_DR8R: next_st.drive_high_current_select = wd;
                    OFS_ODR: next_st.open_drain_select = wd;
                    OFS_PUR: next_st.pull_up_select = wd;
                    OFS_PDR: next_st.pull_down_select = wd;
                    OFS_SLR: next_st.slew_limit_select = wd;
                    OFS_DEN: next_st.digital_input_enable = wd;
                    default: next_st.rdata = st.rdata;
                endcase
            end
        end

        // one-cycle pulse on each new masked trigger-pin condition
        next_st.trig_prev = TRIGGER_USED && irq_masked_status[TRIGGER_PIN];
        next_st.trig = TRIGGER_USED && irq_masked_status[TRIGGER_PIN]
            && !st.trig_prev;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CLK) begin
        if (SRST) begin
            // one reset serves power-on and external reset alike
            st.bus <= GPP_BUS_IDLE;
            st.rdata <= '0;
            st.pin_data_window <= RST_ZERO;
            st.pin_direction <= RST_ZERO;
            st.irq_sense_select <= RST_ZERO;
            st.irq_both_edges <= RST_ZERO;
            st.irq_polarity_event <= RST_ZERO;
            st.irq_enable_mask <= RST_ZERO;
            st.peripheral_control_select <= PERIPH_CTRL_RESET;
            st.drive_low_current_select <= RST_DR2R;
            st.drive_mid_current_select <= RST_ZERO;
            st.drive_high_current_select <= RST_ZERO;
            st.open_drain_select <= RST_ZERO;
            st.pull_up_select <= RST_PUR;
            st.pull_down_select <= RST_ZERO;
            st.slew_limit_select <= RST_ZERO;
            st.digital_input_enable <= RST_DEN;
            st.trig_prev <= 1'b0;
            st.trig <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign DAT_O = st.rdata;
    assign ACK_O = (st.bus == GPP_BUS_ACK);

    // peripheral pins follow the peripheral, direction ignored
    assign PIN_OUT = (st.peripheral_control_select & PERIPH_OUT)
        | (sw_mode & st.pin_data_window & ~st.open_drain_select);
    // on software pins open drain only ever pulls low; peripheral pins ignore it
    assign PIN_OE = (st.peripheral_control_select & PERIPH_OE)
        | (sw_mode & st.pin_direction
        & (~st.open_drain_select | ~st.pin_data_window));
    assign PERIPH_IN = st.peripheral_control_select & pin_seen;

    assign PULL_UP_SELECT = st.pull_up_select;
    assign PULL_DOWN_SELECT = st.pull_down_select;
    assign DRIVE_LOW_CURRENT_SELECT = st.drive_low_current_select;
    assign DRIVE_MID_CURRENT_SELECT = st.drive_mid_current_select;
    assign DRIVE_HIGH_CURRENT_SELECT = st.drive_high_current_select;
    assign SLEW_LIMIT_SELECT = st.slew_limit_select;
    assign DIGITAL_INPUT_ENABLE = st.digital_input_enable;

    assign PORT_IRQ = |irq_masked_status;
    assign CONVERTER_TRIGGER = st.trig;
endmodule

// ### logic/gpp_sync.sv
// two-stage pin synchroniser with a held previous sample
module gpp_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // raw pins and synchronised view
    input wire logic [W-1:0] pin_raw,
    output logic [W-1:0] pin_now,
    output logic [W-1:0] pin_prev
);
    import gpp_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
        logic [1:0] warm;
    } gpp_sync_state_t;

    gpp_sync_state_t st;
    gpp_sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin_raw;
        next_st.s2 = st.s1;
        next_st.prev = st.s2;
        next_st.warm = (st.warm == 2'd3) ? st.warm : st.warm + 2'd1;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pin_now = st.s2;
    // until the stages hold real samples, no edge: a pulled-up pin would look like a rise
    assign pin_prev = (st.warm == 2'd3) ? st.prev : st.s2;
endmodule

// ### sim/gpp_pin_model.sv
// far-side pins: outside drivers, pull resistors, floating pads
module gpp_pin_model (
    // clock
    input wire logic clk,
    // pad side of the port
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up,
    input wire logic [7:0] pull_down,
    // outside drivers
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_drive,
    output logic [7:0] pin_in
);
    logic [7:0] last = 8'h00;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drive[i]) begin
                pin_in[i] = ext_level[i];
            end else if (pull_up[i] || pull_down[i]) begin
                pin_in[i] = pull_up[i];
            end else begin
                // floating pad toggles so no stale value passes for a real one
                pin_in[i] = ~last[i];
            end
        end
    end
    always_ff @(posedge clk) begin
        last <= pin_in;
    end
endmodule

// ### sim/gpp_port_chk.sv
// concurrent checks on the pins of the eight-pin port block
module gpp_port_chk #(
    parameter logic [7:0] PERIPH_CTRL_RESET = 8'h00
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // bus
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    // pins and pad settings
    input wire logic [7:0] PIN_IN,
    input wire logic [7:0] PIN_OE,
    input wire logic [7:0] PERIPH_OE,
    input wire logic [7:0] PULL_UP_SELECT,
    input wire logic [7:0] DRIVE_LOW_CURRENT_SELECT,
    input wire logic [7:0] SLEW_LIMIT_SELECT,
    input wire logic [7:0] DIGITAL_INPUT_ENABLE,
    // interrupt and trigger
    input wire logic PORT_IRQ,
    input wire logic CONVERTER_TRIGGER
);
    ////////////////////////////////////////////////////////////////////////
    // cycles since the pins last moved; an irq edge needs a cause
    typedef struct packed {logic [7:0] last; logic [3:0] quiet;} gpp_chk_t;
    gpp_chk_t st;
    gpp_chk_t next_st;
    always_comb begin
        next_st.last = PIN_IN;
        next_st.quiet = st.quiet + {3'h0, st.quiet != 4'hF};
        if (PIN_IN != st.last || SRST) begin
            next_st.quiet = 4'h0;
        end
    end
    always_ff @(posedge CLK) begin
        st <= next_st;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    ack_one_cycle_a: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    ack_follows_req_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acknowledged next cycle");
    ack_needs_req_a: assert property (!(CYC_I && STB_I) |=> !ACK_O)
        else $error("ack without request");
    read_hold_a: assert property (!ACK_O |-> $stable(DAT_O))
        else $error("read data moved without ack");
    read_upper_a: assert property (DAT_O[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    pad_hold_a: assert property (!ACK_O |-> $stable({PULL_UP_SELECT,
        DRIVE_LOW_CURRENT_SELECT, SLEW_LIMIT_SELECT, DIGITAL_INPUT_ENABLE}))
        else $error("pad setting moved without a write");
    reset_pads_a: assert property (disable iff (1'b0) $fell(SRST) |->
        PULL_UP_SELECT == 8'hFF && DRIVE_LOW_CURRENT_SELECT == 8'hFF
        && DIGITAL_INPUT_ENABLE == 8'hFF && SLEW_LIMIT_SELECT == 8'h00
        && !PORT_IRQ && !ACK_O && DAT_O == 32'h0000_0000)
        else $error("pad or bus state wrong after reset");
    reset_pins_a: assert property (disable iff (1'b0) $fell(SRST) |->
        PIN_OE == (PERIPH_OE & PERIPH_CTRL_RESET))
        else $error("pin enables wrong after reset");
    irq_rise_cause_a: assert property ($rose(PORT_IRQ) |->
        (ACK_O && WE_I) || st.quiet < 4'h8)
        else $error("irq rose with no pin change or write");
    irq_fall_cause_a: assert property ($fell(PORT_IRQ) |->
        (ACK_O && WE_I) || st.quiet < 4'h8)
        else $error("irq fell with no clear write or pin change");
    trig_pulse_a: assert property (CONVERTER_TRIGGER |=> !CONVERTER_TRIGGER)
        else $error("converter trigger longer than one cycle");
    trig_irq_a: assert property (CONVERTER_TRIGGER |-> $past(PORT_IRQ))
        else $error("converter trigger without port irq");
endmodule
bind gpp_port gpp_port_chk #(.PERIPH_CTRL_RESET(PERIPH_CTRL_RESET)) u_chk (.*);

// ### sim/tb.sv
// self-checking bench for the eight-pin port block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpp_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:2] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, rdat_q;
    logic ack, irq, trig;
    logic [7:0] pin_in, pin_out, pin_oe, per_in, pu, pd, den;
    logic [7:0] per_out = 8'hA5;
    logic [7:0] per_oe = 8'hFF;
    logic [7:0] ext_level = 8'h00;
    logic [7:0] ext_drive = 8'hF0;
    int fail_count = 0;
    int checks = 0;
    int trig_count = 0;
    logic [11:0] ofs [18] = '{OFS_DIR, OFS_IS, OFS_IBE, OFS_IEV, OFS_IM, OFS_RIS, OFS_MIS,
        OFS_ICR, OFS_AFSEL, OFS_DR2R, OFS_DR4R, OFS_DR8R, OFS_ODR, OFS_PUR, OFS_PDR,
        OFS_SLR, OFS_DEN, 12'hFE0};
    logic [7:0] rv [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h80, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00};

    initial begin
        forever #2.5 clk = ~clk;
    end
    gpp_port #(.PERIPH_CTRL_RESET(8'h80), .TRIGGER_USED(1'b1), .TRIGGER_PIN(4)) DUT (
        .CLK(clk), .SRST(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PERIPH_OUT(per_out), .PERIPH_OE(per_oe),
        .PERIPH_IN(per_in), .PULL_UP_SELECT(pu), .PULL_DOWN_SELECT(pd),
        .DRIVE_LOW_CURRENT_SELECT(), .DRIVE_MID_CURRENT_SELECT(),
        .DRIVE_HIGH_CURRENT_SELECT(), .SLEW_LIMIT_SELECT(), .DIGITAL_INPUT_ENABLE(den),
        .PORT_IRQ(irq), .CONVERTER_TRIGGER(trig));
    gpp_pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pu),
        .pull_down(pd), .ext_level(ext_level), .ext_drive(ext_drive), .pin_in(pin_in));
    always @(posedge clk) begin
        if (trig === 1'b1) trig_count++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a[11:2];
        sel <= 4'h1;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) begin
            fail_count++;
            $display("unexpected bus ack: expected 1, seen %b", ack);
            wrap_up();
        end else begin
            rdat_q = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, a, 8'h00);
        check(what, rdat_q, {24'h00_0000, exp});
    endtask
    // pins move, then enough edges for sync and flag
    task automatic pins(input logic [7:0] v);
        @(posedge clk);
        ext_level <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic reset_tab;
        foreach (ofs[i]) rd(ofs[i], rv[i], "reset value");
        rd(OFS_DATA_END, 8'h8F, "data after reset");
        check("pin enable after reset", pin_oe, per_oe & 8'h80);
        $display("test reset values done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        reset_tab();
        wr(OFS_AFSEL, 8'h00);
        wr(OFS_DIR, 8'h0F);
        wr(OFS_DATA_END, 8'hFF);
        wr(12'h098, 8'hEB);
        check("driven pins", pin_out & pin_oe, 8'h0B);
        pins(8'h50);
        rd(OFS_DATA_END, 8'h5B, "data full");
        rd(12'h0C4, 8'h11, "data masked");
        for (int i = 0; i < 4; i++) wr(12'(4 << i), 8'h00);
        check("aliased clears", pin_out & pin_oe, 8'h00);
        $display("test data window done");
        pins(8'h00);
        wr(OFS_IS, 8'h80);
        wr(OFS_IBE, 8'h10);
        wr(OFS_IEV, 8'hC0);
        wr(OFS_ICR, 8'hFF);
        pins(8'h70);
        rd(OFS_RIS, 8'h50, "raw rise");
        rd(OFS_MIS, 8'h00, "masked off");
        check("irq masked", irq, 1'b0);
        wr(OFS_IM, 8'h50);
        rd(OFS_MIS, 8'h50, "masked on");
        check("irq", irq, 1'b1);
        check("trigger count", trig_count, 1);
        wr(OFS_ICR, 8'h00);
        rd(OFS_RIS, 8'h50, "clear zero");
        wr(OFS_ICR, 8'h10);
        rd(OFS_RIS, 8'h40, "clear one");
        wr(OFS_ICR, 8'h40);
        check("irq cleared", irq, 1'b0);
        pins(8'h00);
        rd(OFS_RIS, 8'h30, "raw fall");
        check("trigger count", trig_count, 2);
        wr(OFS_ICR, 8'hFF);
        wr(OFS_IM, 8'h80);
        // level held high until read back
        pins(8'h80);
        check("irq level", irq, 1'b1);
        wr(OFS_ICR, 8'h80);
        rd(OFS_RIS, 8'h80, "level kept");
        pins(8'h00);
        rd(OFS_RIS, 8'h00, "level gone");
        $display("test interrupts done");
        wr(OFS_AFSEL, 8'h01);
        check("periph pin", pin_out & pin_oe, 8'h01);
        repeat (4) @(posedge clk);
        check("periph in", per_in, 8'h01);
        per_oe <= 8'hFE;
        @(posedge clk);
        check("dir ignored", pin_oe, 8'h0E);
        wr(OFS_ODR, 8'h02);
        check("open drain low", {pin_out[1], pin_oe[1]}, 2'b01);
        wr(12'h008, 8'h02);
        check("open drain released", pin_oe & 8'h02, 8'h00);
        $display("test peripheral control done");
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        reset_tab();
        wrap_up();
    end
endmodule
